// ---- rtl/uad_detect.sv ----
// Accessory and charger detection timing with link front end
`timescale 1ns/10ps
`include "uad_map.svh"
module uad_detect #(
	parameter int unsigned MS_CYCLES = `UAD_MS_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclClk,
	input wire logic sdaIn,
	input wire logic sclIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic vbusValidIn,
	input wire logic id_sense_pin_float,
	input wire logic [4:0] idCodeIn,
	input wire logic dataContactIn,
	input wire logic [1:0] portKindIn,
	input wire logic ovpIn,
	input wire logic ocpIn,
	input wire logic micOvpIn,
	input wire logic dcdTimeoutEnable,
	input wire logic id_detect_disable,
	input wire logic manual_switch_enable,
	input wire logic manualFetClose,
	input wire logic manualUsbClose,
	input wire logic microphone_line_on_vbus,
	input wire logic irqMaskAll,
	input wire logic [3:0] detectTime,
	output logic irq_out_n,
	output logic charger_found_n_out,
	output logic charger_found_n_oe,
	output logic fetClose,
	output logic usbSwitchClose,
	output logic vbusDisconnect,
	output logic micPathOpen,
	output logic carKitFound,
	output logic accessoryFound,
	output logic bc12Active,
	output logic dataContactFound,
	output logic [7:0] irqFlags,
	output logic [7:0] linkWrPtr,
	output logic [7:0] linkWrData,
	output logic linkWrStb
);
	uad_pkg::uad_main_s q, d;
	logic [1:0] rstSync;
	logic rstN;
	logic [15:0] linkWord;
	logic linkTgl;
	logic linkSdaOe;
	logic linkSdaOut;

	// Measurement length per setting; unlisted settings fall back to the shortest
	function automatic logic [9:0] detectMs(input logic [3:0] sel);
		logic [9:0] r;
		r = 10'(`UAD_DETMS_0);
		case (sel)
			4'h1: r = 10'(`UAD_DETMS_1);
			4'h2: r = 10'(`UAD_DETMS_2);
			4'h3: r = 10'(`UAD_DETMS_3);
			4'h4: r = 10'(`UAD_DETMS_4);
			4'h5: r = 10'(`UAD_DETMS_5);
			4'h6: r = 10'(`UAD_DETMS_6);
			4'h7: r = 10'(`UAD_DETMS_7);
			4'h8: r = 10'(`UAD_DETMS_8);
			4'h9: r = 10'(`UAD_DETMS_9);
			4'hA: r = 10'(`UAD_DETMS_A);
			4'hB: r = 10'(`UAD_DETMS_B);
			default: r = 10'(`UAD_DETMS_0);
		endcase
		return r;
	endfunction : detectMs

	// Needs a run of differing samples longer than a spike before the level moves
	function automatic logic [3:0] spikeFilt(input logic smp, input logic f, input logic [2:0] cnt);
		logic [3:0] r;
		r = {f, 3'h0};
		if (smp != f) begin
			if (cnt == 3'(`UAD_SPIKE_CYC - 1)) begin
				r = {smp, 3'h0};
			end else begin
				r = {f, cnt + 3'h1};
			end
		end
		return r;
	endfunction : spikeFilt

	function automatic logic tAt(input logic [10:0] t, input int unsigned ms);
		return t >= 11'(ms);
	endfunction : tAt

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	uad_link uLink (
		.sclClk(sclClk),
		.linkHold(q.linkHold),
		.sdaIn(sdaIn),
		.statusIn(q.status),
		.sdaOe(linkSdaOe),
		.sdaOut(linkSdaOut),
		.wrWord(linkWord),
		.wrTgl(linkTgl)
	);

	always_comb begin
		logic vb;
		logic idf;
		logic ovp;
		logic ocp;
		logic microphone_line;
		logic [7:0] setF;
		logic [7:0] clrF;
		vb = 1'b0;
		idf = 1'b0;
		ovp = 1'b0;
		ocp = 1'b0;
		microphone_line = 1'b0;
		setF = 8'h00;
		clrF = 8'h00;
		d = q;

		d.sdaS = {q.sdaS[0], sdaIn};
		d.sclS = {q.sclS[0], sclIn};
		{d.sdaF, d.sdaCnt} = spikeFilt(q.sdaS[1], q.sdaF, q.sdaCnt);
		{d.sclF, d.sclCnt} = spikeFilt(q.sclS[1], q.sclF, q.sclCnt);
		d.sdaPrev = q.sdaF;

		d.msTick = 1'b0;
		if (q.msCnt == 17'(MS_CYCLES - 1)) begin
			d.msCnt = 17'h0;
			d.msTick = 1'b1;
		end else begin
			d.msCnt = q.msCnt + 17'h1;
		end

		// One tick more than the figure, since the first millisecond is partial
		d.softRst = 1'b0;
		if (q.sdaF || q.sclF) begin
			d.lowMs = 5'h0;
		end else if (q.msTick && (q.lowMs <= 5'(`UAD_I2CRST_MS))) begin
			d.lowMs = q.lowMs + 5'h1;
			d.softRst = (q.lowMs == 5'(`UAD_I2CRST_MS));
		end

		if (!q.sclF) begin
			d.linkHold = 1'b0;
		end
		if (q.sclF && (q.sdaPrev != q.sdaF)) begin
			d.linkHold = 1'b1;
		end

		d.wrS = {q.wrS[1:0], linkTgl};
		// A held engine drops its toggle to zero; that is not a write
		d.wrStb = !q.linkHold && (q.wrS[2] ^ q.wrS[1]);
		if (d.wrStb) begin
			d.wrPtr = linkWord[15:8];
			d.wrData = linkWord[7:0];
			if (linkWord[15:8] == `UAD_PTR_IRQ) begin
				clrF = linkWord[7:0];
			end
		end

		d.inS1 = {vbusValidIn, id_sense_pin_float, dataContactIn, ovpIn, ocpIn, micOvpIn, portKindIn};
		d.inS2 = q.inS1;
		d.inPrev = q.inS2;
		d.idS1 = idCodeIn;
		d.idS2 = q.idS1;
		vb = q.inS2[`UAD_IN_VBUS];
		idf = q.inS2[`UAD_IN_IDF];
		ovp = q.inS2[`UAD_IN_OVP];
		ocp = q.inS2[`UAD_IN_OCP];
		microphone_line = q.inS2[`UAD_IN_MIC] && microphone_line_on_vbus;

		setF[`UAD_FLG_VBUS] = vb ^ q.inPrev[`UAD_IN_VBUS];
		setF[`UAD_FLG_OVP] = ovp ^ q.inPrev[`UAD_IN_OVP];
		setF[`UAD_FLG_OCP] = ocp ^ q.inPrev[`UAD_IN_OCP];
		setF[`UAD_FLG_MIC] = microphone_line ^ (q.inPrev[`UAD_IN_MIC] && microphone_line_on_vbus);

		if (q.msTick && (q.det.tMs != 11'h7FF)) begin
			d.det.tMs = q.det.tMs + 11'h1;
		end

		case (q.det.st)
			uad_pkg::ST_IDLE: begin
				d.det.tMs = 11'h0;
				d.det.subMs = 10'h0;
				d.det.idPass = 2'h0;
				if (vb) begin
					if ((q.idS2 == `UAD_CODE_CAR1) || (q.idS2 == `UAD_CODE_CAR2)) begin
						d.det.st = uad_pkg::ST_CARKIT;
					end else begin
						d.det.st = uad_pkg::ST_DCD;
						d.det.bc12Act = 1'b1;
						d.det.dcdFound = 1'b0;
					end
				end else if (!idf) begin
					d.det.st = uad_pkg::ST_IDMEAS;
				end
			end
			uad_pkg::ST_DCD: begin
				if (q.msTick) begin
					d.det.subMs = q.det.subMs + 10'h1;
				end
				if (!vb) begin
					d.det.st = uad_pkg::ST_IDLE;
					d.det.bc12Act = 1'b0;
				end else if (q.inS2[`UAD_IN_DC]) begin
					d.det.dcdFound = 1'b1;
					d.det.st = uad_pkg::ST_BC;
				end else if (dcdTimeoutEnable && (q.det.subMs >= 10'(`UAD_DCD_MS))) begin
					d.det.st = uad_pkg::ST_BC;
				end
			end
			uad_pkg::ST_BC: begin
				if (!vb) begin
					d.det.st = uad_pkg::ST_IDLE;
					d.det.bc12Act = 1'b0;
				end else if (q.inS2[1:0] == `UAD_KIND_SDP) begin
					if (tAt(q.det.tMs, `UAD_SDP_MS)) begin
						d.det.grant = 1'b1;
						d.det.usb = 1'b1;
						d.det.bc12Act = 1'b0;
						setF[`UAD_FLG_BC] = 1'b1;
						d.det.st = uad_pkg::ST_ATTACHED;
					end
				end else if (tAt(q.det.tMs, `UAD_CHG_MS)) begin
					d.det.grant = 1'b1;
					d.det.chgOe = 1'b1;
					d.det.usb = (q.inS2[1:0] == `UAD_KIND_CDP);
					d.det.bc12Act = 1'b0;
					setF[`UAD_FLG_BC] = 1'b1;
					d.det.st = uad_pkg::ST_ATTACHED;
				end
			end
			uad_pkg::ST_CARKIT: begin
				if (!vb) begin
					d.det.st = uad_pkg::ST_IDLE;
				end else if (tAt(q.det.tMs, `UAD_CARKIT_MS)) begin
					d.det.carKit = 1'b1;
					d.det.grant = 1'b1;
					d.det.chgOe = 1'b1;
					setF[`UAD_FLG_RES] = 1'b1;
					d.det.st = uad_pkg::ST_ATTACHED;
				end
			end
			uad_pkg::ST_IDMEAS: begin
				if (idf || vb) begin
					d.det.st = uad_pkg::ST_IDLE;
				end else if (q.msTick) begin
					if (q.det.subMs == detectMs(detectTime) - 10'h1) begin
						d.det.subMs = 10'h0;
						d.det.idPass = q.det.idPass + 2'h1;
						if (q.det.idPass == 2'(`UAD_ID_PASSES - 1)) begin
							d.det.acc = 1'b1;
							setF[`UAD_FLG_RES] = 1'b1;
							d.det.st = uad_pkg::ST_ATTACHED;
						end
					end else begin
						d.det.subMs = q.det.subMs + 10'h1;
					end
				end
			end
			uad_pkg::ST_ATTACHED: begin
				if (!vb && idf) begin
					if (q.det.acc || q.det.carKit) begin
						setF[`UAD_FLG_RES] = 1'b1;
					end
					d.det.st = uad_pkg::ST_IDLE;
					d.det.grant = 1'b0;
					d.det.usb = 1'b0;
					d.det.chgOe = 1'b0;
					d.det.carKit = 1'b0;
					d.det.acc = 1'b0;
				end else if (!vb) begin
					d.det.grant = 1'b0;
					d.det.usb = 1'b0;
					d.det.chgOe = 1'b0;
				end
			end
			default: begin
				d.det.st = uad_pkg::ST_IDLE;
			end
		endcase

		// Later resistance changes are muted once a resistance is settled and detect is disabled
		if (id_detect_disable && (q.det.st == uad_pkg::ST_ATTACHED) && !idf) begin
			setF[`UAD_FLG_RES] = 1'b0;
		end

		// A new event beats a clear in the same cycle
		d.det.flags = ((q.det.flags & ~clrF) | setF) & `UAD_FLG_USED;
		d.det.irqN = ~((|q.det.flags) && !irqMaskAll);

		if (manual_switch_enable) begin
			d.fet = manualFetClose && vb && !ovp && !ocp;
		end else begin
			d.fet = q.det.grant && vb && !ovp && !ocp;
		end
		d.det.usb = d.det.usb && (q.det.st != uad_pkg::ST_IDLE);
		d.vbDisc = ovp;
		d.micOpen = microphone_line;
		d.chgOut = 1'b0;
		d.status = {1'b0, ocp, ovp, microphone_line, ~idf, vb, q.det.bc12Act, q.det.dcdFound};

		// Protection comparators and the link engine keep running through this
		if (q.softRst) begin
			d.det = '0;
			d.det.irqN = 1'b1;
			d.fet = 1'b0;
		end
		d.usbSw = manual_switch_enable ? manualUsbClose : d.det.usb;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			q <= '0;
			q.sdaS <= 2'h3;
			q.sclS <= 2'h3;
			q.sdaF <= 1'b1;
			q.sclF <= 1'b1;
			q.sdaPrev <= 1'b1;
			q.linkHold <= 1'b1;
			q.inS1 <= `UAD_IN_IDLE;
			q.inS2 <= `UAD_IN_IDLE;
			q.inPrev <= `UAD_IN_IDLE;
			q.det.irqN <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign sdaOe = linkSdaOe;
	assign sdaOut = linkSdaOut;
	assign irq_out_n = q.det.irqN;
	assign charger_found_n_out = q.chgOut;
	assign charger_found_n_oe = q.det.chgOe;
	assign fetClose = q.fet;
	assign usbSwitchClose = q.usbSw;
	assign vbusDisconnect = q.vbDisc;
	assign micPathOpen = q.micOpen;
	assign carKitFound = q.det.carKit;
	assign accessoryFound = q.det.acc;
	assign bc12Active = q.det.bc12Act;
	assign dataContactFound = q.det.dcdFound;
	assign irqFlags = q.det.flags;
	assign linkWrPtr = q.wrPtr;
	assign linkWrData = q.wrData;
	assign linkWrStb = q.wrStb;
endmodule : uad_detect

// ---- rtl/uad_link.sv ----
// Link-side byte engine running on the SCL clock
`timescale 1ns/10ps
`include "uad_map.svh"
module uad_link (
	input wire logic sclClk,
	input wire logic linkHold,
	input wire logic sdaIn,
	input wire logic [7:0] statusIn,
	output logic sdaOe,
	output logic sdaOut,
	output logic [15:0] wrWord,
	output logic wrTgl
);
	uad_pkg::uad_link_s q, d;
	logic addrHit;
	logic ackNow;

	always_comb begin
		addrHit = (q.shift[7:1] == `UAD_SLAVE_ADDR);
		ackNow = (q.bitCnt == 4'h8) && (((q.st == uad_pkg::LK_ADDR) && addrHit) ||
			(q.st == uad_pkg::LK_PTR) || (q.st == uad_pkg::LK_DATA));
		d = q;
		d.stS1 = statusIn;
		d.stS2 = q.stS1;
		if (q.bitCnt != 4'h8) begin
			d.shift = {q.shift[6:0], sdaIn};
			d.bitCnt = q.bitCnt + 4'h1;
			if (q.st == uad_pkg::LK_READ) begin
				d.rdByte = {q.rdByte[6:0], 1'b0};
			end
		end else begin
			d.bitCnt = 4'h0;
			case (q.st)
				uad_pkg::LK_ADDR: begin
					if (addrHit && q.shift[0]) begin
						d.st = uad_pkg::LK_READ;
						d.rdByte = q.stS2;
					end else if (addrHit) begin
						d.st = uad_pkg::LK_PTR;
					end else begin
						d.st = uad_pkg::LK_SKIP;
					end
				end
				uad_pkg::LK_PTR: begin
					d.ptr = q.shift;
					d.st = uad_pkg::LK_DATA;
				end
				uad_pkg::LK_DATA: begin
					d.wrWord = {q.ptr, q.shift};
					d.wrTgl = ~q.wrTgl;
					d.ptr = q.ptr + 8'h01;
				end
				uad_pkg::LK_READ: begin
					if (sdaIn) begin
						d.st = uad_pkg::LK_SKIP;
					end else begin
						d.rdByte = q.stS2;
					end
				end
				default: begin
					d.st = uad_pkg::LK_SKIP;
				end
			endcase
		end
	end

	// Hold comes from the system domain; it frames every transfer at start and stop so no edge outside a frame is needed
	always_ff @(posedge sclClk or posedge linkHold) begin
		if (linkHold) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Drive while SCL is low so data never moves during the high phase
	always_ff @(negedge sclClk or posedge linkHold) begin
		if (linkHold) begin
			sdaOe <= 1'b0;
			sdaOut <= 1'b0;
		end else begin
			sdaOe <= ackNow || ((q.st == uad_pkg::LK_READ) && (q.bitCnt != 4'h8) && !q.rdByte[7]);
			sdaOut <= 1'b0;
		end
	end

	assign wrWord = q.wrWord;
	assign wrTgl = q.wrTgl;
endmodule : uad_link

// ---- shared/uad_map.svh ----
// Constant map for the accessory-detect timing block
`ifndef UAD_MAP_SVH
`define UAD_MAP_SVH
`define UAD_SLAVE_ADDR 7'h25
`define UAD_CLK_NS 8
`define UAD_CLK_HZ 125000000
`define UAD_SPIKE_NS 50
`define UAD_SPIKE_CYC ((`UAD_SPIKE_NS + `UAD_CLK_NS - 1) / `UAD_CLK_NS)
`define UAD_MS_CYC (`UAD_CLK_HZ / 1000)
`define UAD_I2CRST_MS 30
`define UAD_SDP_MS 120
`define UAD_CHG_MS 160
`define UAD_CARKIT_MS 140
`define UAD_DCD_MS 600
`define UAD_ID_PASSES 3
`define UAD_DETMS_0 50
`define UAD_DETMS_1 100
`define UAD_DETMS_2 150
`define UAD_DETMS_3 200
`define UAD_DETMS_4 300
`define UAD_DETMS_5 400
`define UAD_DETMS_6 500
`define UAD_DETMS_7 600
`define UAD_DETMS_8 700
`define UAD_DETMS_9 800
`define UAD_DETMS_A 900
`define UAD_DETMS_B 1000
`define UAD_FLG_USED 8'h7E
`define UAD_IN_IDLE 8'h40
`define UAD_CODE_CAR1 5'h07
`define UAD_CODE_CAR2 5'h03
`define UAD_KIND_SDP 2'h0
`define UAD_KIND_CDP 2'h1
`define UAD_KIND_DCP 2'h2
`define UAD_PTR_IRQ 8'h03
`define UAD_FLG_OCP 6
`define UAD_FLG_OVP 5
`define UAD_FLG_MIC 4
`define UAD_FLG_RES 3
`define UAD_FLG_VBUS 2
`define UAD_FLG_BC 1
`define UAD_IN_VBUS 7
`define UAD_IN_IDF 6
`define UAD_IN_DC 5
`define UAD_IN_OVP 4
`define UAD_IN_OCP 3
`define UAD_IN_MIC 2
`endif

// ---- shared/uad_pkg.sv ----
// Types shared by the accessory-detect timing block
package uad_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_DCD, ST_BC, ST_CARKIT, ST_IDMEAS, ST_ATTACHED} uad_state_e;
	typedef enum logic [2:0] {LK_ADDR, LK_PTR, LK_DATA, LK_READ, LK_SKIP} uad_link_e;
	typedef struct packed {
		uad_state_e st;
		logic [10:0] tMs;
		logic [9:0] subMs;
		logic [1:0] idPass;
		logic grant;
		logic usb;
		logic chgOe;
		logic carKit;
		logic acc;
		logic bc12Act;
		logic dcdFound;
		logic [7:0] flags;
		logic irqN;
	} uad_det_s;
	typedef struct packed {
		logic [1:0] sdaS;
		logic [1:0] sclS;
		logic sdaF;
		logic sclF;
		logic sdaPrev;
		logic [2:0] sdaCnt;
		logic [2:0] sclCnt;
		logic [16:0] msCnt;
		logic msTick;
		logic [4:0] lowMs;
		logic softRst;
		logic linkHold;
		logic [2:0] wrS;
		logic [7:0] wrPtr;
		logic [7:0] wrData;
		logic wrStb;
		logic [7:0] inS1;
		logic [7:0] inS2;
		logic [7:0] inPrev;
		logic fet;
		logic vbDisc;
		logic micOpen;
		logic chgOut;
		logic [7:0] status;
		logic [4:0] idS1;
		logic [4:0] idS2;
		logic usbSw;
		uad_det_s det;
	} uad_main_s;
	typedef struct packed {
		uad_link_e st;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic [15:0] wrWord;
		logic wrTgl;
		logic [7:0] rdByte;
		logic [7:0] stS1;
		logic [7:0] stS2;
	} uad_link_s;
endpackage : uad_pkg

// ---- testbench/tb_usb_port_accessory_detect_timing.sv ----
// Top-level bench for the accessory-detect timing block
`timescale 1ns/10ps
`include "uad_map.svh"
module tb_usb_port_accessory_detect_timing;
	localparam int MS = 10;
	localparam int LIMIT = 60000;
	logic clk, nrst, vbus, idFloat, contact, ovp, ocp, microphone_line, dcdEn, micVbus, mask;
	logic [4:0] idCode;
	logic [1:0] kind;
	logic [3:0] detTime;
	logic scl, mOe, sda, sdaOe, sdaOut, irqN, chgOut, chgOe, fet, usb, disc, micOpen, car, acc, bcAct, dcFound, wrStb;
	logic [7:0] flags, wrPtr, wrData;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int stbCnt = 0;
	// Pulled-up open-drain data line
	assign sda = !(mOe || sdaOe);
	uad_detect #(.MS_CYCLES(MS)) uut (
		.clk(clk), .nrst(nrst), .sclClk(scl), .sdaIn(sda), .sclIn(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.vbusValidIn(vbus), .id_sense_pin_float(idFloat), .idCodeIn(idCode), .dataContactIn(contact),
		.portKindIn(kind), .ovpIn(ovp), .ocpIn(ocp), .micOvpIn(microphone_line), .dcdTimeoutEnable(dcdEn),
		.id_detect_disable(1'h0), .manual_switch_enable(1'h0), .manualFetClose(1'h0), .manualUsbClose(1'h0),
		.microphone_line_on_vbus(micVbus), .irqMaskAll(mask), .detectTime(detTime), .irq_out_n(irqN),
		.charger_found_n_out(chgOut), .charger_found_n_oe(chgOe), .fetClose(fet), .usbSwitchClose(usb),
		.vbusDisconnect(disc), .micPathOpen(micOpen), .carKitFound(car), .accessoryFound(acc),
		.bc12Active(bcAct), .dataContactFound(dcFound), .irqFlags(flags), .linkWrPtr(wrPtr),
		.linkWrData(wrData), .linkWrStb(wrStb)
	);
	uad_i2c_master m (.scl(scl), .sdaOe(mOe), .sda(sda));
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	task automatic rst();
		nrst = 1'h0;
		vbus = 1'h0;
		idFloat = 1'h1;
		idCode = 5'h00;
		contact = 1'h1;
		kind = `UAD_KIND_SDP;
		{ovp, ocp, microphone_line, micVbus, mask} = 5'h00;
		dcdEn = 1'h1;
		detTime = 4'h0;
		repeat (8) @(negedge clk);
		nrst = 1'h1;
		repeat (4) @(negedge clk);
	endtask : rst
	task automatic wms(input int n);
		repeat (n * MS) @(negedge clk);
	endtask : wms
	task automatic t_port(input logic [1:0] k, input int ms, input logic u, input logic o);
		rst();
		kind = k;
		vbus = 1'h1;
		wms(ms - 5);
		chk(fet, 1'h0);
		wms(10);
		chk(fet, 1'h1);
		chk(usb, u);
		chk(chgOe, o);
		chk(dcFound, 1'h1);
		chk(flags[1], 1'h1);
		chk(irqN, 1'h0);
		$display("port kind %0d done", k);
	endtask : t_port
	task automatic t_link();
		logic a;
		int s0;
		s0 = stbCnt;
		m.start();
		m.wbyte(8'h4A, a);
		chk(a, 1'h1);
		m.wbyte(`UAD_PTR_IRQ, a);
		m.wbyte(8'hFF, a);
		chk(a, 1'h1);
		m.stop();
		@(negedge clk);
		chk(wrPtr, `UAD_PTR_IRQ);
		chk(wrData, 8'hFF);
		chk(8'(stbCnt - s0), 8'h01);
		chk(flags, 8'h00);
		chk(irqN, 1'h1);
		m.start();
		m.wbyte(8'h4C, a);
		chk(a, 1'h0);
		m.stop();
		$display("link done");
	endtask : t_link
	task automatic t_car(input logic [4:0] code);
		rst();
		idFloat = 1'h0;
		idCode = code;
		vbus = 1'h1;
		wms(135);
		chk(car, 1'h0);
		wms(10);
		chk(car, 1'h1);
		chk(chgOe, 1'h1);
		$display("car kit %h done", code);
	endtask : t_car
	task automatic t_dcd(input logic en);
		rst();
		contact = 1'h0;
		dcdEn = en;
		vbus = 1'h1;
		wms(595);
		chk(fet, 1'h0);
		chk(bcAct, 1'h1);
		wms(15);
		chk(fet, en);
		chk(bcAct, !en);
		chk(dcFound, 1'h0);
		$display("contact timeout %0d done", en);
	endtask : t_dcd
	task automatic t_id(input logic [3:0] t, input int ms);
		rst();
		detTime = t;
		idFloat = 1'h0;
		idCode = 5'h0A;
		wms(ms - 5);
		chk(acc, 1'h0);
		wms(10);
		chk(acc, 1'h1);
		chk(irqN, 1'h0);
		$display("id setting %0d done", t);
	endtask : t_id
	task automatic t_low();
		mask = 1'h1;
		repeat (4) @(negedge clk);
		chk(irqN, 1'h1);
		mask = 1'h0;
		repeat (4) @(negedge clk);
		chk(irqN, 1'h0);
		m.busLow();
		wms(15);
		m.spike();
		wms(13);
		chk(acc, 1'h1);
		wms(5);
		chk(acc, 1'h0);
		chk(irqN, 1'h1);
		wms(20);
		m.busFree();
		$display("held-low reset done");
	endtask : t_low
	task automatic t_prot();
		logic a;
		logic [7:0] st;
		rst();
		vbus = 1'h1;
		micVbus = 1'h1;
		wms(125);
		ovp = 1'h1;
		repeat (8) @(negedge clk);
		chk(disc, 1'h1);
		chk(fet, 1'h0);
		chk(flags[5], 1'h1);
		ovp = 1'h0;
		repeat (8) @(negedge clk);
		chk(fet, 1'h1);
		ocp = 1'h1;
		repeat (8) @(negedge clk);
		chk(fet, 1'h0);
		chk(flags[6], 1'h1);
		microphone_line = 1'h1;
		repeat (8) @(negedge clk);
		chk(micOpen, 1'h1);
		chk(flags[4], 1'h1);
		m.start();
		m.wbyte(8'h4B, a);
		chk(a, 1'h1);
		m.rbyte(1'h1, st);
		chk(st, 8'h55);
		m.stop();
		$display("protection done");
	endtask : t_prot
	always @(posedge clk) begin
		if (wrStb === 1'h1) begin
			stbCnt <= stbCnt + 1;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		rst();
		chk(irqN, 1'h1);
		chk(flags, 8'h00);
		t_port(`UAD_KIND_CDP, 160, 1'h1, 1'h1);
		t_port(`UAD_KIND_DCP, 160, 1'h0, 1'h1);
		t_port(`UAD_KIND_SDP, 120, 1'h1, 1'h0);
		t_link();
		t_car(`UAD_CODE_CAR1);
		t_car(`UAD_CODE_CAR2);
		t_dcd(1'h1);
		t_dcd(1'h0);
		t_id(4'h0, 150);
		t_id(4'h1, 300);
		t_id(4'hC, 150);
		t_low();
		t_prot();
		test_done();
	end
endmodule : tb_usb_port_accessory_detect_timing

// ---- testbench/uad_detect_sva.sv ----
// Assertion checker for the accessory-detect timing block
`timescale 1ns/10ps
`include "uad_map.svh"
module uad_detect_sva #(
	parameter int unsigned MS_CYCLES = `UAD_MS_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclClk,
	input wire logic sdaIn,
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic ovpIn,
	input wire logic ocpIn,
	input wire logic manual_switch_enable,
	input wire logic [1:0] portKindIn,
	input wire logic irqMaskAll,
	input wire logic irq_out_n,
	input wire logic charger_found_n_out,
	input wire logic charger_found_n_oe,
	input wire logic fetClose,
	input wire logic usbSwitchClose,
	input wire logic vbusDisconnect,
	input wire logic accessoryFound,
	input wire logic [7:0] irqFlags
);
	localparam int LIM = 31 * MS_CYCLES + 30;
	int lowCnt;
	// Raw pins: a spike restarts this count, so the check only gets later
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lowCnt <= 0;
		end else if (sdaIn || sclIn) begin
			lowCnt <= 0;
		end else if (lowCnt != LIM) begin
			lowCnt <= lowCnt + 1;
		end
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (!nrst);
	fet_ovp_a: assert property (!manual_switch_enable throughout ovpIn [*5] |-> !fetClose)
		else $error("charger switch closed under over-voltage");
	fet_ocp_a: assert property ((ocpIn && !manual_switch_enable) [*5] |-> !fetClose)
		else $error("charger switch closed under over-current");
	ovp_disc_a: assert property (ovpIn [*5] |-> vbusDisconnect)
		else $error("supply not disconnected under over-voltage");
	chg_od_a: assert property (!charger_found_n_out)
		else $error("charger output driven high");
	irq_mask_a: assert property (irqMaskAll [*3] |-> irq_out_n)
		else $error("interrupt low while masked");
	irq_flag_a: assert property ((irqFlags != 8'h00 && !irqMaskAll) [*3] |-> !irq_out_n)
		else $error("interrupt high with flag set");
	irq_idle_a: assert property ((irqFlags == 8'h00) [*3] |-> irq_out_n)
		else $error("interrupt low without flag");
	dcp_usb_a: assert property ((!manual_switch_enable && portKindIn == `UAD_KIND_DCP) [*4] |-> !usbSwitchClose)
		else $error("data switches closed for dedicated port");
	sda_ack_a: assert property ($rose(sdaOe) |-> !sclClk && !sdaOut)
		else $error("data line taken while clock high");
	low_rst_a: assert property (lowCnt == LIM |-> !accessoryFound && !fetClose && irq_out_n)
		else $error("held-low reset missing");
	cover property (fetClose && usbSwitchClose);
	cover property (charger_found_n_oe && !usbSwitchClose);
	cover property (lowCnt == LIM);
endmodule : uad_detect_sva
bind uad_detect uad_detect_sva #(.MS_CYCLES(MS_CYCLES)) uadChk (
	.clk(clk), .nrst(nrst), .sclClk(sclClk), .sdaIn(sdaIn), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.ovpIn(ovpIn), .ocpIn(ocpIn), .manual_switch_enable(manual_switch_enable), .portKindIn(portKindIn),
	.irqMaskAll(irqMaskAll), .irq_out_n(irq_out_n), .charger_found_n_out(charger_found_n_out),
	.charger_found_n_oe(charger_found_n_oe), .fetClose(fetClose), .usbSwitchClose(usbSwitchClose),
	.vbusDisconnect(vbusDisconnect), .accessoryFound(accessoryFound), .irqFlags(irqFlags)
);

// ---- testbench/uad_i2c_master.sv ----
// Link master model standing in for the host processor
`timescale 1ns/10ps
module uad_i2c_master (
	output logic scl,
	output logic sdaOe,
	input wire logic sda
);
	// Both lines released; clock toggles inside frames and, outside them, in the held-low and spike tasks
	initial begin
		scl = 1'h1;
		sdaOe = 1'h0;
	end
	// Bench rate runs above fast mode to keep runs short
	task automatic bitx(input logic b, output logic r);
		#20 sdaOe = !b;
		#20 scl = 1'h1;
		r = sda;
		#40 scl = 1'h0;
	endtask : bitx
	// Long low after start lets the filtered start reach the byte engine
	// Extra nanosecond keeps link edges off the system clock edges
	task automatic start();
		#21 sdaOe = 1'h0;
		#20 scl = 1'h1;
		#200 sdaOe = 1'h1;
		#200 scl = 1'h0;
		#200;
	endtask : start
	task automatic stop();
		#20 sdaOe = 1'h1;
		#20 scl = 1'h1;
		#200 sdaOe = 1'h0;
		#200;
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'h1, r);
		ack = !r;
	endtask : wbyte
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		d = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'h1, r);
			d = {d[6:0], r};
		end
		bitx(last, r);
	endtask : rbyte
	task automatic busLow();
		sdaOe = 1'h1;
		#101 scl = 1'h0;
	endtask : busLow
	task automatic busFree();
		scl = 1'h1;
		#101 sdaOe = 1'h0;
		#200;
	endtask : busFree
	task automatic spike();
		scl = 1'h1;
		#40 scl = 1'h0;
	endtask : spike
endmodule : uad_i2c_master
